// *** rtl/cic_pkg.sv ***
// Constants, field layouts and carrier type of the capture/compare flag block
//
// Summary of operation
// RULE1 - Period flag sets at timer 1 period
// RULE2 - Period flag holds until software clears
// RULE3 - Direction flag sets at zero, mode 1
// RULE4 - Direction flag holds until software clears
// RULE5 - Capture rising edge sets up flag
// RULE6 - Compare match counting up sets up flag
// RULE7 - Capture falling edge sets down flag
// RULE8 - Down match sets down flag, mode 1
// RULE9 - Enable register bit layout, bits 7..0
// RULE10 - Period enable gates period interrupt
// RULE11 - Direction enable ignored in mode 0
// RULE12 - Rise enable works in both modes
// RULE13 - Fall enable, compare only mode 1
// RULE14 - Compare output drives push-pull initial level
// RULE15 - Initial-level write changes outputs immediately
// RULE16 - Software programs levels before timer start
// RULE17 - Invert bit inverts second unit signal
// RULE18 - Aux level before timer 2, or disabled
// RULE19 - Initial bit gives inactive PWM level
// RULE20 - Trap forces outputs to initial levels
// RULE21 - Even bits channel pins, odd complementary
// RULE22 - Software must clear match flags
// RULE23 - Interrupt is OR of enabled flags
package cic_pkg;
  // ****************************************
  // Register indices, byte address is four times
  // ****************************************
  localparam logic [7:0] CIC_IDX_INIT_LEVELS = 8'hE2;
  localparam logic [7:0] CIC_IDX_IRQ_ENABLES = 8'hD6;
  localparam logic [7:0] CIC_IDX_IRQ_FLAGS = 8'hE5;
  localparam logic [7:0] CIC_IDX_CTRL = 8'hF0;
  localparam int CIC_ADDR_W = 10;
  localparam int CIC_CHANNELS = 3;
  localparam int CIC_OUTS = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CIC_RST_ENABLES = 8'h00;
  localparam logic [7:0] CIC_RST_FLAGS = 8'h00;
  localparam logic [7:0] CIC_RST_INIT_LEVELS = 8'hFF;
  localparam logic [15:0] CIC_RST_CTRL = 16'h0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CIC_BIT_PERIOD = 7;
  localparam int CIC_BIT_DIRCHG = 6;
  localparam int CIC_BIT_AUX_INIT = 7;
  localparam int CIC_BIT_COMM_INV = 6;
  localparam int CIC_CTRL_MODE = 0;
  localparam int CIC_CTRL_CAPSEL = 1;
  localparam int CIC_CTRL_OUTSEL = 4;
  localparam int CIC_CTRL_BURST = 10;

  // ****************************************
  // Carrier from compare timer 1
  // ****************************************
  typedef struct packed {
    logic period;
    logic zero_rev;
    logic count_up;
    logic running;
    logic [CIC_CHANNELS-1:0] match;
  } cic_t1_evt_t;
endpackage

// *** rtl/cic_top.sv ***
// Flags, enables and compare output levels of the capture/compare unit
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module cic_top (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic [cic_pkg::CIC_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire cic_pkg::cic_t1_evt_t I_T1_EVT,
  input wire logic [cic_pkg::CIC_CHANNELS-1:0] I_CAP_PIN,
  input wire logic [cic_pkg::CIC_OUTS-1:0] I_PWM_ACTIVE,
  input wire logic I_T2_OUT,
  input wire logic I_T2_RUN,
  input wire logic I_AUX_OUT_EN,
  input wire logic I_TRAP_STATE,
  input wire logic [cic_pkg::CIC_OUTS-1:0] I_TRAP_EN,
  output logic [cic_pkg::CIC_OUTS-1:0] O_CMP_OUT,
  output logic [cic_pkg::CIC_OUTS-1:0] O_CMP_OE_N,
  output logic O_AUX_OUT,
  output logic O_IRQ
);
  // ****************************************
  // Bus access
  // ****************************************
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic en);
    lane_merge = en ? new_v : old_v;
  endfunction

  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] idx;
  logic acc_take, wr_take;
  logic wr_en, wr_flags, wr_init, wr_ctrl;

  assign idx = I_AVS_ADDRESS[cic_pkg::CIC_ADDR_W-1:2];
  // Request is answered one cycle after it is first seen
  assign acc_take = (I_AVS_READ || I_AVS_WRITE) && !wait_q;
  assign wr_take = I_AVS_WRITE && !wait_q;
  assign wr_en = wr_take && (idx == cic_pkg::CIC_IDX_IRQ_ENABLES);
  assign wr_flags = wr_take && (idx == cic_pkg::CIC_IDX_IRQ_FLAGS);
  assign wr_init = wr_take && (idx == cic_pkg::CIC_IDX_INIT_LEVELS);
  assign wr_ctrl = wr_take && (idx == cic_pkg::CIC_IDX_CTRL);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] en_q, en_d;
  logic [7:0] flags_q, flags_d;
  logic [7:0] init_q, init_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [7:0] flag_set;

  logic mode1;
  logic [cic_pkg::CIC_CHANNELS-1:0] cap_sel;
  logic [cic_pkg::CIC_OUTS-1:0] out_sel;
  logic burst;
  assign mode1 = ctrl_q[cic_pkg::CIC_CTRL_MODE];
  assign cap_sel = ctrl_q[cic_pkg::CIC_CTRL_CAPSEL +: cic_pkg::CIC_CHANNELS];
  assign out_sel = ctrl_q[cic_pkg::CIC_CTRL_OUTSEL +: cic_pkg::CIC_OUTS];
  assign burst = ctrl_q[cic_pkg::CIC_CTRL_BURST];

  always_comb begin
    wait_d = !((I_AVS_READ || I_AVS_WRITE) && wait_q);
    rdata_d = rdata_q;
    if ((I_AVS_READ || I_AVS_WRITE) && wait_q) begin
      if (idx == cic_pkg::CIC_IDX_IRQ_ENABLES) begin
        rdata_d = {24'h000000, en_q};
      end else if (idx == cic_pkg::CIC_IDX_IRQ_FLAGS) begin
        rdata_d = {24'h000000, flags_q};
      end else if (idx == cic_pkg::CIC_IDX_INIT_LEVELS) begin
        rdata_d = {24'h000000, init_q};
      end else if (idx == cic_pkg::CIC_IDX_CTRL) begin
        rdata_d = {16'h0000, ctrl_q};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  always_comb begin
    en_d = en_q;
    init_d = init_q;
    ctrl_d = ctrl_q;
    flags_d = flags_q;
    if (wr_en) begin
      en_d = lane_merge(en_q, I_AVS_WRITEDATA[7:0], I_AVS_BYTEENABLE[0]); // RULE9
    end
    if (wr_init) begin
      init_d = lane_merge(init_q, I_AVS_WRITEDATA[7:0], I_AVS_BYTEENABLE[0]); // RULE15
    end
    if (wr_ctrl) begin
      ctrl_d[7:0] = lane_merge(ctrl_q[7:0], I_AVS_WRITEDATA[7:0], I_AVS_BYTEENABLE[0]);
      ctrl_d[15:8] = lane_merge(ctrl_q[15:8], I_AVS_WRITEDATA[15:8], I_AVS_BYTEENABLE[1]);
    end
    if (wr_flags) begin
      flags_d = lane_merge(flags_q, I_AVS_WRITEDATA[7:0], I_AVS_BYTEENABLE[0]); // RULE22
    end
    // Hardware set wins over a software clear in the same cycle
    flags_d = flags_d | flag_set; // RULE2 RULE4
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      en_q <= cic_pkg::CIC_RST_ENABLES;
      flags_q <= cic_pkg::CIC_RST_FLAGS;
      init_q <= cic_pkg::CIC_RST_INIT_LEVELS;
      ctrl_q <= cic_pkg::CIC_RST_CTRL;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      en_q <= en_d;
      flags_q <= flags_d;
      init_q <= init_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign O_AVS_WAITREQUEST = wait_q;
  assign O_AVS_READDATA = rdata_q;

  // ****************************************
  // Capture pin synchroniser and edges
  // ****************************************
  logic [cic_pkg::CIC_CHANNELS-1:0] cap_s1_q, cap_s2_q, cap_s3_q;
  logic [cic_pkg::CIC_CHANNELS-1:0] rise, fall;
  assign rise = cap_s2_q & ~cap_s3_q;
  assign fall = ~cap_s2_q & cap_s3_q;

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      cap_s1_q <= '0;
      cap_s2_q <= '0;
      cap_s3_q <= '0;
    end else begin
      cap_s1_q <= I_CAP_PIN;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
    end
  end

  // ****************************************
  // Flag set events
  // ****************************************
  always_comb begin
    flag_set = 8'h00;
    flag_set[cic_pkg::CIC_BIT_PERIOD] = I_T1_EVT.period; // RULE1
    flag_set[cic_pkg::CIC_BIT_DIRCHG] = I_T1_EVT.zero_rev && mode1; // RULE3
    for (int c = 0; c < cic_pkg::CIC_CHANNELS; c++) begin
      if (cap_sel[c]) begin
        flag_set[2*c] = rise[c]; // RULE5
        flag_set[2*c+1] = fall[c]; // RULE7
      end else begin
        flag_set[2*c] = I_T1_EVT.match[c] && I_T1_EVT.count_up; // RULE6
        // Down matches only exist when the timer counts both ways
        flag_set[2*c+1] = I_T1_EVT.match[c] && !I_T1_EVT.count_up && mode1; // RULE8
      end
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  logic irq_q, irq_d;
  logic [7:0] en_eff;
  always_comb begin
    en_eff = en_q;
    en_eff[cic_pkg::CIC_BIT_DIRCHG] = en_q[cic_pkg::CIC_BIT_DIRCHG] && mode1; // RULE11
    irq_d = |(flags_q & en_eff); // RULE23 RULE10 RULE12 RULE13
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end
  assign O_IRQ = irq_q;

  // ****************************************
  // Compare outputs
  // ****************************************
  logic [cic_pkg::CIC_OUTS-1:0] out_q, out_d, oe_n_q, oe_n_d;
  logic aux_q, aux_d, t2_seen_q, t2_seen_d;
  logic comm_sig;
  assign comm_sig = I_T2_OUT ^ init_q[cic_pkg::CIC_BIT_COMM_INV]; // RULE17

  always_comb begin
    for (int i = 0; i < cic_pkg::CIC_OUTS; i++) begin
      // Even index is a channel pin, odd its complementary pin
      oe_n_d[i] = !out_sel[i]; // RULE14 RULE21
      if (!out_sel[i] || !I_T1_EVT.running) begin
        out_d[i] = init_q[i]; // RULE14
      end else if (I_TRAP_STATE && I_TRAP_EN[i]) begin
        out_d[i] = init_q[i]; // RULE20
      end else if (burst) begin
        out_d[i] = comm_sig; // RULE17
      end else begin
        // Inactive phase takes the initial level, so a write shows at once
        out_d[i] = I_PWM_ACTIVE[i] ? !init_q[i] : init_q[i]; // RULE19 RULE15
      end
    end
    t2_seen_d = t2_seen_q || I_T2_RUN;
    if (!t2_seen_q || !I_AUX_OUT_EN) begin
      aux_d = init_q[cic_pkg::CIC_BIT_AUX_INIT]; // RULE18
    end else begin
      aux_d = I_T2_OUT;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      out_q <= '1;
      oe_n_q <= '1;
      aux_q <= 1'b1;
      t2_seen_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      aux_q <= aux_d;
      t2_seen_q <= t2_seen_d;
    end
  end
  assign O_CMP_OUT = out_q;
  assign O_CMP_OE_N = oe_n_q;
  assign O_AUX_OUT = aux_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  AST_PERIOD_SET: assert property (I_T1_EVT.period |=> flags_q[7]) // RULE1
    else $error("period flag not set");
  AST_PERIOD_HOLD: assert property (flags_q[7] && !wr_flags |=> flags_q[7]) // RULE2
    else $error("period flag dropped without software");
  AST_DIR_MODE0: assert property (!mode1 && !flags_q[6] && !wr_flags |=> !flags_q[6]) // RULE3
    else $error("direction flag set in mode 0");
  AST_DIR_HOLD: assert property (flags_q[6] && !wr_flags |=> flags_q[6]) // RULE4
    else $error("direction flag dropped");
  AST_CAP_RISE: assert property (cap_sel[0] && rise[0] |=> flags_q[0]) // RULE5
    else $error("rising capture flag missing");
  AST_CMP_UP: assert property (!cap_sel[1] && I_T1_EVT.match[1] && I_T1_EVT.count_up // RULE6
                               |=> flags_q[2])
    else $error("up match flag missing");
  AST_CAP_FALL: assert property ($fell(cap_s2_q[2]) && cap_sel[2] |=> flags_q[5]) // RULE7
    else $error("falling capture flag missing");
  AST_CMP_DOWN: assert property (!cap_sel[0] && I_T1_EVT.match[0] && !I_T1_EVT.count_up // RULE8
                                 && !mode1 && !flags_q[1] && !wr_flags |=> !flags_q[1])
    else $error("down match flag set in mode 0");
  AST_IRQ: assert property ((flags_q[7] && en_q[7]) |=> O_IRQ) // RULE23
    else $error("interrupt not raised");
  AST_IRQ_OFF: assert property ((flags_q & en_eff) == 8'h00 |=> !O_IRQ) // RULE10
    else $error("interrupt without enabled flag");
  AST_OE: assert property (out_sel[3] |=> !O_CMP_OE_N[3]) // RULE14
    else $error("compare pin not driven");
  AST_TRAP: assert property (out_sel[0] && I_TRAP_STATE && I_TRAP_EN[0] // RULE20
                             |=> O_CMP_OUT[0] == $past(init_q[0]))
    else $error("trap level wrong");
  AST_BUS: assert property ((I_AVS_READ || I_AVS_WRITE) && wait_q |=> !O_AVS_WAITREQUEST)
    else $error("bus answer late");

  // ****************************************
  // Bus answer checks
  // ****************************************
  logic rd_ask;
  assign rd_ask = I_AVS_READ && wait_q;

  AST_BUS_RELEASE: assert property (acc_take |=> O_AVS_WAITREQUEST)
    else $error("waitrequest not raised after answer");
  AST_RD_EN: assert property (rd_ask && idx == cic_pkg::CIC_IDX_IRQ_ENABLES // RULE9
                              |=> O_AVS_READDATA == {24'h000000, $past(en_q)})
    else $error("enable register read wrong");
  AST_RD_FLAGS: assert property (rd_ask && idx == cic_pkg::CIC_IDX_IRQ_FLAGS // RULE2
                                 |=> O_AVS_READDATA == {24'h000000, $past(flags_q)})
    else $error("flag register read wrong");
  AST_RD_INIT: assert property (rd_ask && idx == cic_pkg::CIC_IDX_INIT_LEVELS // RULE15
                                |=> O_AVS_READDATA == {24'h000000, $past(init_q)})
    else $error("initial level read wrong");
  AST_RD_NONE: assert property (rd_ask && idx < cic_pkg::CIC_IDX_IRQ_ENABLES
                                |=> O_AVS_READDATA == 32'h00000000)
    else $error("unmapped read not zero");
  AST_WR_EN: assert property (wr_en && I_AVS_BYTEENABLE[0] // RULE9
                              |=> en_q == $past(I_AVS_WRITEDATA[7:0]))
    else $error("enable write lost");
  AST_WR_INIT: assert property (wr_init && I_AVS_BYTEENABLE[0] // RULE15
                                |=> init_q == $past(I_AVS_WRITEDATA[7:0]))
    else $error("initial level write lost");
  AST_WR_FLAGS: assert property (wr_flags && I_AVS_BYTEENABLE[0] && flag_set == 8'h00 // RULE22
                                 |=> flags_q == $past(I_AVS_WRITEDATA[7:0]))
    else $error("flag write lost");

  // ****************************************
  // Flag set checks
  // ****************************************
  AST_DIR_SET: assert property (I_T1_EVT.zero_rev && mode1 |=> flags_q[6]) // RULE3
    else $error("direction flag not set");
  AST_CAP_RISE1: assert property (cap_sel[1] && rise[1] |=> flags_q[2]) // RULE5
    else $error("rising capture flag missing on channel 1");
  AST_CAP_RISE2: assert property (cap_sel[2] && rise[2] |=> flags_q[4]) // RULE5
    else $error("rising capture flag missing on channel 2");
  AST_CAP_FALL0: assert property (cap_sel[0] && fall[0] |=> flags_q[1]) // RULE7
    else $error("falling capture flag missing on channel 0");
  AST_CAP_FALL1: assert property (cap_sel[1] && fall[1] |=> flags_q[3]) // RULE7
    else $error("falling capture flag missing on channel 1");
  AST_CMP_UP0: assert property (!cap_sel[0] && I_T1_EVT.match[0] && I_T1_EVT.count_up // RULE6
                                |=> flags_q[0])
    else $error("up match flag missing on channel 0");
  AST_CMP_UP2: assert property (!cap_sel[2] && I_T1_EVT.match[2] && I_T1_EVT.count_up // RULE6
                                |=> flags_q[4])
    else $error("up match flag missing on channel 2");
  AST_CMP_DN1: assert property (!cap_sel[1] && I_T1_EVT.match[1] && !I_T1_EVT.count_up // RULE8
                                && mode1 |=> flags_q[3])
    else $error("down match flag missing on channel 1");
  AST_CMP_DN2: assert property (!cap_sel[2] && I_T1_EVT.match[2] && !I_T1_EVT.count_up // RULE8
                                && mode1 |=> flags_q[5])
    else $error("down match flag missing on channel 2");

  // ****************************************
  // Interrupt checks
  // ****************************************
  AST_IRQ_DIR: assert property (flags_q[6] && en_q[6] && mode1 |=> O_IRQ) // RULE11
    else $error("direction interrupt missing");
  AST_IRQ_DIR_MODE0: assert property (!mode1 && (flags_q & en_q & 8'hBF) == 8'h00 // RULE11
                                      |=> !O_IRQ)
    else $error("direction enable acted in mode 0");
  AST_IRQ_PERIOD_OFF: assert property (flags_q == 8'h80 && !en_q[7] |=> !O_IRQ) // RULE10
    else $error("period interrupt while disabled");
  AST_IRQ_RISE: assert property (flags_q[2] && en_q[2] |=> O_IRQ) // RULE12
    else $error("rising interrupt missing");
  AST_IRQ_FALL: assert property (flags_q[5] && en_q[5] |=> O_IRQ) // RULE13
    else $error("falling interrupt missing");

  // ****************************************
  // Output checks
  // ****************************************
  AST_OE_OFF: assert property (!out_sel[2] |=> O_CMP_OE_N[2]) // RULE14
    else $error("unselected pin driven");
  AST_PAIR: assert property (out_sel[2] && !out_sel[3] // RULE21
                             |=> !O_CMP_OE_N[2] && O_CMP_OE_N[3])
    else $error("channel and complementary pin mixed up");
  AST_IDLE_LEVEL: assert property (out_sel[1] && !I_T1_EVT.running // RULE14
                                   |=> O_CMP_OUT[1] == $past(init_q[1]))
    else $error("initial level not driven");
  AST_INACTIVE: assert property (!burst && !I_PWM_ACTIVE[4] // RULE19
                                 |=> O_CMP_OUT[4] == $past(init_q[4]))
    else $error("inactive phase level wrong");
  AST_ACTIVE: assert property (out_sel[4] && I_T1_EVT.running && !I_TRAP_STATE && !burst // RULE19
                               && I_PWM_ACTIVE[4] |=> O_CMP_OUT[4] == !$past(init_q[4]))
    else $error("active phase level wrong");
  AST_BURST: assert property (out_sel[5] && I_T1_EVT.running && !I_TRAP_STATE && burst // RULE17
                              |=> O_CMP_OUT[5] == ($past(I_T2_OUT) ^ $past(init_q[6])))
    else $error("burst output inversion wrong");
  AST_AUX_OFF: assert property (!I_AUX_OUT_EN |=> O_AUX_OUT == $past(init_q[7])) // RULE18
    else $error("disabled aux level wrong");
  AST_AUX_BEFORE: assert property (!t2_seen_q |=> O_AUX_OUT == $past(init_q[7])) // RULE18
    else $error("aux level before timer 2 wrong");
  AST_AUX_RUN: assert property (t2_seen_q && I_AUX_OUT_EN // RULE18
                                |=> O_AUX_OUT == $past(I_T2_OUT))
    else $error("aux output not following timer 2");

  COV_PERIOD_IRQ: cover property (I_T1_EVT.period && en_q[7] ##2 O_IRQ);
  COV_CAPTURE: cover property (cap_sel[0] && rise[0] ##1 flags_q[0]);
  COV_TRAP: cover property (I_TRAP_STATE && I_TRAP_EN[1] && out_sel[1]);
  COV_CLEAR_RACE: cover property (wr_flags && flag_set != 8'h00);
  COV_BURST: cover property (burst && out_sel[5] && I_T1_EVT.running);
endmodule
`default_nettype wire

// *** verif/cic_pin_model.sv ***
// Pin-side model of the capture inputs and compare pads
`timescale 1ns/1ns
`default_nettype none
module cic_pin_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_level,
  input wire logic i_slow,
  input wire logic [5:0] i_cmp_out,
  input wire logic [5:0] i_oe_n,
  output logic [5:0] o_pad
);
  logic [2:0] dly_q;
  logic [2:0] lvl_q;
  // ****************************************
  // Capture source, slow mode lags a cycle
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dly_q <= 3'h0;
      lvl_q <= 3'h0;
    end else begin
      dly_q <= i_level;
      lvl_q <= i_slow ? dly_q : i_level;
    end
  end
  // ****************************************
  // Pad levels; undriven odd pads show the inverted compare output
  // ****************************************
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      o_pad[2*c] = i_oe_n[2*c] ? lvl_q[c] : i_cmp_out[2*c];
      o_pad[2*c+1] = i_oe_n[2*c+1] ? ~i_cmp_out[2*c+1] : i_cmp_out[2*c+1];
    end
  end
endmodule
`default_nettype wire

// *** verif/capture_compare_unit_irq_flags_and_output_init_tb_top.sv ***
// Self-checking bench of the flag, enable and output level block
`timescale 1ns/1ns
`default_nettype none
module capture_compare_unit_irq_flags_and_output_init_tb_top;
  localparam logic [7:0] EN = cic_pkg::CIC_IDX_IRQ_ENABLES;
  localparam logic [7:0] FL = cic_pkg::CIC_IDX_IRQ_FLAGS;
  localparam logic [7:0] IL = cic_pkg::CIC_IDX_INIT_LEVELS;
  localparam logic [7:0] CT = cic_pkg::CIC_IDX_CTRL;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] av_addr = 10'h000;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0;
  cic_pkg::cic_t1_evt_t t1 = '0;
  logic [5:0] pwm = 6'h00;
  logic t2_out = 1'b0;
  logic t2_run = 1'b0;
  logic aux_en = 1'b1;
  logic trap = 1'b0;
  logic [5:0] trap_en = 6'h00;
  logic [2:0] lvl = 3'h0;
  logic slow = 1'b0;
  logic samp = 1'b0;
  logic [5:0] pad;
  logic [31:0] rdata;
  logic wreq;
  logic irq;
  logic aux;
  logic [5:0] cmp;
  logic [5:0] oe_n;
  logic [31:0] exp_q[$];
  int seed = 6652;
  int miscompares = 0;
  int comparisons = 0;
  logic [7:0] r;
  logic [5:0] p;
  logic [5:0] tm;

  always #5 clk = ~clk;

  cic_top cic_top_i (.I_SYS_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd),
    .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .I_T1_EVT(t1),
    .I_CAP_PIN({pad[4], pad[2], pad[0]}), .I_PWM_ACTIVE(pwm), .I_T2_OUT(t2_out),
    .I_T2_RUN(t2_run), .I_AUX_OUT_EN(aux_en), .I_TRAP_STATE(trap), .I_TRAP_EN(trap_en),
    .O_CMP_OUT(cmp), .O_CMP_OE_N(oe_n), .O_AUX_OUT(aux), .O_IRQ(irq));
  cic_pin_model cic_pin_model_i (.i_clk(clk), .i_rst(rst), .i_level(lvl), .i_slow(slow),
    .i_cmp_out(cmp), .i_oe_n(oe_n), .o_pad(pad));

  // ****************************************
  // Result watcher, oldest note first
  // ****************************************
  always @(posedge clk) begin
    if ((av_rd && wreq === 1'b0) || samp) begin
      comparisons++;
      if (exp_q.size() == 0 || exp_q[0] !== (samp ? {18'h0, irq, aux, oe_n, cmp} : rdata)) begin
        miscompares++;
        $display("unexpected at %0t: result mismatch", $time);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    @(posedge clk);
    av_addr <= {idx, 2'b00};
    av_rd <= ~w;
    av_wr <= w;
    av_wd <= {16'h0000, d};
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 16'h0);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic chk(input logic [13:0] e);
    exp_q.push_back({18'h0, e});
    @(posedge clk);
    samp <= 1'b1;
    @(posedge clk);
    samp <= 1'b0;
  endtask
  // Timer events are one-cycle pulses; levels stay
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    t1 <= e;
    @(posedge clk);
    t1 <= e & 7'h18;
    repeat (3) @(posedge clk);
  endtask
  task end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(EN, 32'h0);
    rd(FL, 32'h0);
    rd(IL, 32'hFF);
    rd(8'h10, 32'h0);
    chk(14'h1FFF);
    pulse(7'h40);
    rd(FL, 32'h80);
    chk(14'h1FFF);
    wr(EN, 16'h80);
    chk(14'h3FFF);
    rd(FL, 32'h80);
    wr(FL, 16'h0);
    chk(14'h1FFF);
    wr(EN, 16'hC0);
    for (int m = 0; m < 2; m++) begin
      wr(CT, m[15:0]);
      pulse(7'h20);
      rd(FL, m ? 32'h40 : 32'h0);
      chk({m[0], 13'h1FFF});
      wr(FL, 16'h0);
    end
    wr(EN, 16'h3F);
    for (int m = 0; m < 2; m++) begin
      wr(CT, m[15:0]);
      for (int c = 0; c < 3; c++) begin
        pulse(7'h10 | (7'h1 << c));
        rd(FL, 32'h1 << (2 * c));
        chk(14'h3FFF);
        wr(FL, 16'h0);
        pulse(7'h1 << c);
        rd(FL, m << (2 * c + 1));
        chk({m[0], 13'h1FFF});
        wr(FL, 16'h0);
      end
    end
    // Capture on all channels, slow pin on channel 1
    wr(CT, 16'h000E);
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      slow <= c[0];
      lvl <= 3'h1 << c;
      repeat (8) @(posedge clk);
      rd(FL, 32'h1 << (2 * c));
      chk(14'h3FFF);
      wr(FL, 16'h0);
      @(posedge clk);
      lvl <= 3'h0;
      repeat (8) @(posedge clk);
      rd(FL, 32'h2 << (2 * c));
      chk(14'h3FFF);
      wr(FL, 16'h0);
    end
    wr(EN, 16'h0);
    wr(CT, 16'h0150);
    chk({1'b0, 1'b1, 6'h2A, 6'h3F});
    wr(CT, 16'h03F0);
    chk(14'h103F);
    r = 8'($random(seed));
    wr(IL, {8'h00, r});
    chk({1'b0, r[7], 6'h00, r[5:0]});
    @(posedge clk);
    t1 <= 7'h08;
    r = 8'($random(seed));
    wr(IL, {8'h00, r});
    chk({1'b0, r[7], 6'h00, r[5:0]});
    p = 6'($random(seed));
    tm = 6'($random(seed));
    @(posedge clk);
    pwm <= p;
    chk({1'b0, r[7], 6'h00, r[5:0] ^ p});
    @(posedge clk);
    trap <= 1'b1;
    trap_en <= tm;
    chk({1'b0, r[7], 6'h00, r[5:0] ^ (p & ~tm)});
    @(posedge clk);
    trap <= 1'b0;
    t2_out <= p[0];
    wr(CT, 16'h07F0);
    chk({1'b0, r[7], 6'h00, {6{p[0] ^ r[6]}}});
    @(posedge clk);
    t2_run <= 1'b1;
    aux_en <= 1'b0;
    chk({1'b0, r[7], 6'h00, {6{p[0] ^ r[6]}}});
    @(posedge clk);
    aux_en <= 1'b1;
    chk({1'b0, p[0], 6'h00, {6{p[0] ^ r[6]}}});
    end_of_test;
  end
endmodule
`default_nettype wire
